// >>> thermal_monitor_cfg.svh
`ifndef THERMAL_MONITOR_CFG_SVH
`define THERMAL_MONITOR_CFG_SVH

// ==========================================================
// Register selector values
`define OFS_LOCAL_READING 8'h00
`define OFS_REMOTE_MSB 8'h01
`define OFS_ALARM_FLAGS 8'h02
`define OFS_CFG_RD 8'h03
`define OFS_RATE_RD 8'h04
`define OFS_LOC_UP_RD 8'h05
`define OFS_LOC_LO_RD 8'h06
`define OFS_REM_UP_MSB_RD 8'h07
`define OFS_REM_LO_MSB_RD 8'h08
`define OFS_CFG_WR 8'h09
`define OFS_RATE_WR 8'h0A
`define OFS_LOC_UP_WR 8'h0B
`define OFS_LOC_LO_WR 8'h0C
`define OFS_REM_UP_MSB_WR 8'h0D
`define OFS_REM_LO_MSB_WR 8'h0E
`define OFS_ONE_SHOT 8'h0F
`define OFS_REMOTE_LSB 8'h10
`define OFS_OFFSET_MSB 8'h11
`define OFS_OFFSET_LSB 8'h12
`define OFS_REM_UP_LSB 8'h13
`define OFS_REM_LO_LSB 8'h14
`define OFS_REM_CRIT 8'h19
`define OFS_LOC_CRIT 8'h20
`define OFS_HYSTERESIS 8'h21
`define OFS_FILTER 8'hBF
`define OFS_MAKER_ID 8'hFE
`define OFS_DIE_REV 8'hFF

// ==========================================================
// Reset values
`define RST_RATE 8'h08
`define RST_UPPER 8'h46
`define RST_CRIT 8'h55
`define RST_HYST 5'h0A

// ==========================================================
// Field positions and config write mask
`define CFG_ALERT_MASK 7
`define CFG_STANDBY 6
`define CFG_REMOTE_OVERTEMP_FLAG_MASK 4
`define CFG_LOCAL_OVERTEMP_FLAG_MASK 2
`define CFG_FAULT_QUEUE 0
`define CFG_USED_MASK 8'hD5
`define ST_BUSY 7
`define ST_LOC_OVER 6
`define ST_LOC_UNDER 5
`define ST_REM_OVER 4
`define ST_REM_UNDER 3
`define ST_OPEN 2
`define ST_REM_CRIT 1
`define ST_LOC_CRIT 0
`define FLT_CMP_MODE 0

// ==========================================================
// Timing
`define CONV_BASE_MS 16000
`define CORE_CLK_KHZ 25000
`define RATE_MAX_CODE 4'h9

`endif

// >>> thermal_monitor_pkg.sv
package thermal_monitor_pkg;

    typedef enum logic [1:0] {
        REQ_SET_PTR = 2'h0,
        REQ_WRITE = 2'h1,
        REQ_READ = 2'h2
    } req_kind_e;

    typedef struct packed {
        req_kind_e kind;
        logic [7:0] sel;
        logic [7:0] data;
    } link_req_s;

    typedef enum logic [1:0] {
        CONV_IDLE = 2'h0,
        CONV_RUN = 2'h1,
        CONV_STORE = 2'h3
    } conv_state_e;

endpackage

// >>> thermal_monitor_register_map.sv
`timescale 1ns/1ns
`include "thermal_monitor_cfg.svh"

module thermal_monitor_register_map
    import thermal_monitor_pkg::*;
#(
    parameter int unsigned CONV_BASE_CYCLES = `CONV_BASE_MS * `CORE_CLK_KHZ,
    // Arbitrary identity values
    parameter logic [7:0] MAKER_ID = 8'h5A,
    parameter logic [7:0] DIE_REV = 8'h0C
) (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_link_clk,
    input wire logic i_link_req_valid,
    input wire link_req_s i_link_req,
    output logic o_link_req_ready,
    output logic o_link_rsp_valid,
    output logic [7:0] o_link_rsp_data,
    output logic o_conv_start,
    input wire logic i_conv_done,
    input wire logic signed [9:0] i_local_raw,
    input wire logic signed [13:0] i_remote_raw,
    input wire logic i_diode_open,
    output logic o_limit_alarm_oe,
    output logic o_overtemp_alarm_out_oe
);

    // ==========================================================
    // Functions
    function automatic logic signed [15:0] clamp16(
        input logic signed [15:0] v,
        input logic signed [15:0] lo,
        input logic signed [15:0] hi);
        clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    function automatic logic [1:0] fq_next(input logic now,
        input logic [1:0] cnt);
        fq_next = !now ? 2'h0 : ((cnt == 2'h3) ? 2'h3 : 2'(cnt + 2'h1));
    endfunction

    function automatic logic fq_flag(input logic fq, input logic now,
        input logic [1:0] cnt_n);
        fq_flag = fq ? (cnt_n == 2'h3) : now;
    endfunction

    function automatic logic [31:0] rate_period(input logic [7:0] code);
        logic [3:0] c;
        c = (code > 8'(`RATE_MAX_CODE)) ? `RATE_MAX_CODE : code[3:0];
        rate_period = 32'(CONV_BASE_CYCLES) >> c;
    endfunction

    // ==========================================================
    // Link domain: request capture and answer
    link_req_s hold;
    logic req_tgl;
    logic pending;
    logic ack_tgl;
    logic ack_s1;
    logic ack_s2;
    logic ack_seen;
    logic [7:0] rd_data;

    assign o_link_req_ready = !pending;

    always_ff @(posedge i_link_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            hold <= '0;
            req_tgl <= 1'b0;
        end else if (i_link_req_valid && !pending) begin
            hold <= i_link_req;
            req_tgl <= !req_tgl;
        end
    end

    always_ff @(posedge i_link_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
            ack_seen <= 1'b0;
        end else begin
            ack_s1 <= ack_tgl;
            ack_s2 <= ack_s1;
            ack_seen <= ack_s2;
        end
    end

    always_ff @(posedge i_link_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pending <= 1'b0;
            o_link_rsp_valid <= 1'b0;
            o_link_rsp_data <= 8'h00;
        end else begin
            o_link_rsp_valid <= 1'b0;
            if (i_link_req_valid && !pending) begin
                pending <= 1'b1;
            end else if (ack_s2 != ack_seen) begin
                pending <= 1'b0;
                o_link_rsp_valid <= 1'b1;
                o_link_rsp_data <= rd_data;
            end
        end
    end

    // ==========================================================
    // Core domain: request detection
    logic req_s1;
    logic req_s2;
    logic req_seen;
    logic req_evt;
    logic is_wr;
    logic [7:0] ptr;

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            req_seen <= 1'b0;
        end else begin
            req_s1 <= req_tgl;
            req_s2 <= req_s1;
            req_seen <= req_s2;
        end
    end

    assign req_evt = req_s2 != req_seen;
    assign is_wr = req_evt && (hold.kind == REQ_WRITE);

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ptr <= `OFS_LOCAL_READING;
        end else if (req_evt && (hold.kind != REQ_READ)) begin
            ptr <= hold.sel;
        end
    end

    // ==========================================================
    // Writable registers
    logic [7:0] cfg;
    logic [7:0] rate;
    logic signed [7:0] loc_up;
    logic signed [7:0] loc_lo;
    logic [7:0] rem_up_msb;
    logic [7:0] rem_lo_msb;
    logic [2:0] rem_up_lsb;
    logic [2:0] rem_lo_lsb;
    logic [7:0] ofs_msb;
    logic [2:0] ofs_lsb;
    logic signed [7:0] rem_crit;
    logic signed [7:0] loc_crit;
    logic [4:0] hyst;
    logic [2:0] filt_sel;

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cfg <= 8'h00;
            rate <= `RST_RATE;
            loc_up <= `RST_UPPER;
            loc_lo <= 8'h00;
            rem_up_msb <= `RST_UPPER;
            rem_lo_msb <= 8'h00;
            rem_up_lsb <= 3'h0;
            rem_lo_lsb <= 3'h0;
            ofs_msb <= 8'h00;
            ofs_lsb <= 3'h0;
            rem_crit <= `RST_CRIT;
            loc_crit <= `RST_CRIT;
            hyst <= `RST_HYST;
            filt_sel <= 3'h0;
        end else if (is_wr) begin
            case (hold.sel)
                `OFS_CFG_WR: cfg <= hold.data & `CFG_USED_MASK;
                `OFS_RATE_WR: rate <= hold.data;
                `OFS_LOC_UP_WR: loc_up <= hold.data;
                `OFS_LOC_LO_WR: loc_lo <= hold.data;
                `OFS_REM_UP_MSB_WR: rem_up_msb <= hold.data;
                `OFS_REM_LO_MSB_WR: rem_lo_msb <= hold.data;
                `OFS_REM_UP_LSB: rem_up_lsb <= hold.data[7:5];
                `OFS_REM_LO_LSB: rem_lo_lsb <= hold.data[7:5];
                `OFS_OFFSET_MSB: ofs_msb <= hold.data;
                `OFS_OFFSET_LSB: ofs_lsb <= hold.data[7:5];
                `OFS_REM_CRIT: rem_crit <= hold.data;
                `OFS_LOC_CRIT: loc_crit <= hold.data;
                `OFS_HYSTERESIS: hyst <= hold.data[4:0];
                `OFS_FILTER: filt_sel <= hold.data[2:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Conversion scheduling
    conv_state_e state;
    logic [31:0] rate_cnt;
    logic per_due;
    logic one_due;
    logic start_now;
    logic standby;
    logic busy;
    logic signed [9:0] loc_raw;
    logic signed [13:0] rem_raw;
    logic open_raw;

    assign standby = cfg[`CFG_STANDBY];
    assign busy = state != CONV_IDLE;
    assign start_now = (state == CONV_IDLE)
        && (one_due || (per_due && !standby));

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rate_cnt <= 32'h0000_0000;
        end else if (standby || rate_cnt == 32'h0000_0000) begin
            rate_cnt <= rate_period(rate) - 32'h0000_0001;
        end else begin
            rate_cnt <= rate_cnt - 32'h0000_0001;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            per_due <= 1'b0;
            one_due <= 1'b0;
        end else begin
            if (!standby && rate_cnt == 32'h0000_0000) begin
                per_due <= 1'b1;
            end else if (start_now || standby) begin
                per_due <= 1'b0;
            end
            if (is_wr && hold.sel == `OFS_ONE_SHOT && standby) begin
                one_due <= 1'b1;
            end else if (start_now) begin
                one_due <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state <= CONV_IDLE;
            o_conv_start <= 1'b0;
            loc_raw <= 10'sh000;
            rem_raw <= 14'sh0000;
            open_raw <= 1'b0;
        end else begin
            o_conv_start <= 1'b0;
            case (state)
                CONV_IDLE: begin
                    if (start_now) begin
                        state <= CONV_RUN;
                        o_conv_start <= 1'b1;
                    end
                end
                CONV_RUN: begin
                    if (i_conv_done) begin
                        state <= CONV_STORE;
                        loc_raw <= i_local_raw;
                        rem_raw <= i_remote_raw;
                        open_raw <= i_diode_open;
                    end
                end
                CONV_STORE: state <= CONV_IDLE;
                default: state <= CONV_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Result shaping and limit comparison
    logic signed [15:0] filt_acc;
    logic signed [15:0] rem_in;
    logic signed [15:0] rem_avg;
    logic signed [15:0] rem_corr;
    logic signed [10:0] rem_val;
    logic signed [7:0] loc_val;
    logic signed [7:0] rem_whole;
    logic signed [10:0] rem_up11;
    logic signed [10:0] rem_lo11;
    logic signed [8:0] loc_clr;
    logic signed [8:0] rem_clr;
    logic [6:0] flags;
    logic [6:0] next_flags;
    logic [1:0] cnt_hi;
    logic [1:0] cnt_lo;
    logic [1:0] cnt_cr;
    logic [1:0] next_cnt_hi;
    logic [1:0] next_cnt_lo;
    logic [1:0] next_cnt_cr;
    logic [7:0] loc_reading;
    logic [10:0] rem_reading;

    always_comb begin
        rem_in = 16'(rem_raw);
        case (filt_sel[2:1])
            2'h0: rem_avg = rem_in;
            2'h3: rem_avg = (filt_acc * 16'sh0003 + rem_in) >>> 2;
            default: rem_avg = (filt_acc + rem_in) >>> 1;
        endcase
        rem_corr = rem_avg
            + $signed({{5{ofs_msb[7]}}, ofs_msb, ofs_lsb});
        rem_val = open_raw ? 11'sh3F8
            : 11'(clamp16(rem_corr, -16'sh0400, 16'sh03FF));
        loc_val = 8'(clamp16(16'(loc_raw), -16'sh0080, 16'sh007F));
        rem_up11 = $signed({rem_up_msb, rem_up_lsb});
        rem_lo11 = $signed({rem_lo_msb, rem_lo_lsb});
        loc_clr = 9'(loc_crit) - $signed({4'h0, hyst});
        rem_clr = 9'(rem_crit) - $signed({4'h0, hyst});
        next_cnt_hi = fq_next(rem_val > rem_up11, cnt_hi);
        next_cnt_lo = fq_next(rem_val < rem_lo11, cnt_lo);
        rem_whole = rem_val[10:3];
        next_cnt_cr = fq_next(rem_whole > rem_crit
            || (flags[`ST_REM_CRIT] && 9'(rem_whole) > rem_clr), cnt_cr);
        next_flags[`ST_LOC_OVER] = loc_val > loc_up;
        next_flags[`ST_LOC_UNDER] = loc_val < loc_lo;
        next_flags[`ST_REM_OVER] = fq_flag(cfg[`CFG_FAULT_QUEUE],
            rem_val > rem_up11, next_cnt_hi);
        next_flags[`ST_REM_UNDER] = fq_flag(cfg[`CFG_FAULT_QUEUE],
            rem_val < rem_lo11, next_cnt_lo);
        next_flags[`ST_OPEN] = open_raw;
        next_flags[`ST_REM_CRIT] = fq_flag(cfg[`CFG_FAULT_QUEUE],
            next_cnt_cr != 2'h0, next_cnt_cr);
        next_flags[`ST_LOC_CRIT] = loc_val > loc_crit
            || (flags[`ST_LOC_CRIT] && 9'(loc_val) > loc_clr);
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            flags <= 7'h00;
            cnt_hi <= 2'h0;
            cnt_lo <= 2'h0;
            cnt_cr <= 2'h0;
            filt_acc <= 16'sh0000;
            loc_reading <= 8'h00;
            rem_reading <= 11'h000;
        end else if (state == CONV_STORE) begin
            flags <= next_flags;
            cnt_hi <= next_cnt_hi;
            cnt_lo <= next_cnt_lo;
            cnt_cr <= next_cnt_cr;
            filt_acc <= rem_avg;
            loc_reading <= loc_val;
            rem_reading <= rem_val;
        end
    end

    // ==========================================================
    // Alarm outputs
    logic alert_latch;
    logic status_read;
    logic limit_any;

    assign status_read = req_evt && hold.kind == REQ_READ
        && ptr == `OFS_ALARM_FLAGS;
    assign limit_any = |{flags[6:3], flags[1:0]};

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            alert_latch <= 1'b0;
        end else if (state == CONV_STORE
            && |{next_flags[6:3], next_flags[1:0]}) begin
            alert_latch <= 1'b1;
        end else if (status_read) begin
            alert_latch <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_limit_alarm_oe <= 1'b0;
            o_overtemp_alarm_out_oe <= 1'b0;
        end else begin
            o_limit_alarm_oe <= !cfg[`CFG_ALERT_MASK]
                && (filt_sel[`FLT_CMP_MODE] ? limit_any : alert_latch);
            o_overtemp_alarm_out_oe <=
                (flags[`ST_LOC_CRIT] && !cfg[`CFG_LOCAL_OVERTEMP_FLAG_MASK])
                || (flags[`ST_REM_CRIT] && !cfg[`CFG_REMOTE_OVERTEMP_FLAG_MASK]
                && !flags[`ST_OPEN]);
        end
    end

    // ==========================================================
    // Read path and acknowledge
    logic [7:0] rd_mux;

    always_comb begin
        case (ptr)
            `OFS_LOCAL_READING: rd_mux = loc_reading;
            `OFS_REMOTE_MSB: rd_mux = rem_reading[10:3];
            `OFS_ALARM_FLAGS: rd_mux = {busy, flags};
            `OFS_CFG_RD: rd_mux = cfg;
            `OFS_RATE_RD: rd_mux = rate;
            `OFS_LOC_UP_RD: rd_mux = loc_up;
            `OFS_LOC_LO_RD: rd_mux = loc_lo;
            `OFS_REM_UP_MSB_RD: rd_mux = rem_up_msb;
            `OFS_REM_LO_MSB_RD: rd_mux = rem_lo_msb;
            `OFS_REMOTE_LSB: rd_mux = {rem_reading[2:0], 5'h00};
            `OFS_OFFSET_MSB: rd_mux = ofs_msb;
            `OFS_OFFSET_LSB: rd_mux = {ofs_lsb, 5'h00};
            `OFS_REM_UP_LSB: rd_mux = {rem_up_lsb, 5'h00};
            `OFS_REM_LO_LSB: rd_mux = {rem_lo_lsb, 5'h00};
            `OFS_REM_CRIT: rd_mux = rem_crit;
            `OFS_LOC_CRIT: rd_mux = loc_crit;
            `OFS_HYSTERESIS: rd_mux = {3'h0, hyst};
            `OFS_FILTER: rd_mux = {5'h00, filt_sel};
            `OFS_MAKER_ID: rd_mux = MAKER_ID;
            `OFS_DIE_REV: rd_mux = DIE_REV;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rd_data <= 8'h00;
            ack_tgl <= 1'b0;
        end else if (req_evt) begin
            rd_data <= (hold.kind == REQ_READ) ? rd_mux : 8'h00;
            ack_tgl <= !ack_tgl;
        end
    end

    // ==========================================================
    // Assertions
    ptr_follow_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rstn)
        req_evt && hold.kind != REQ_READ |=> ptr == $past(hold.sel))
        else $error("selector not taken from command byte");

    oneshot_read_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rstn)
        req_evt && hold.kind == REQ_READ && ptr == `OFS_ONE_SHOT
        |=> rd_data == 8'h00)
        else $error("one-shot location read non-zero");

    cfg_write_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rstn)
        is_wr && hold.sel == `OFS_CFG_WR
        |=> cfg == ($past(hold.data) & `CFG_USED_MASK))
        else $error("config write address not honoured");

    cfg_read_addr_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rstn)
        is_wr && hold.sel == `OFS_CFG_RD |=> $stable(cfg))
        else $error("config changed by write to read address");

    start_busy_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rstn)
        start_now |=> busy ##0 o_conv_start ##1 !o_conv_start)
        else $error("busy or start pulse wrong");

    standby_stop_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rstn)
        standby && !one_due |=> !o_conv_start)
        else $error("conversion started in standby");

    oneshot_run_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rstn)
        is_wr && hold.sel == `OFS_ONE_SHOT && standby && !busy && !one_due
        |-> ##[1:3] o_conv_start)
        else $error("one-shot did not start a conversion");

    overtemp_mask_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rstn)
        cfg[`CFG_REMOTE_OVERTEMP_FLAG_MASK] && cfg[`CFG_LOCAL_OVERTEMP_FLAG_MASK]
        |=> !o_overtemp_alarm_out_oe)
        else $error("overtemp output active while masked");

    alert_mask_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rstn)
        cfg[`CFG_ALERT_MASK] |=> !o_limit_alarm_oe)
        else $error("limit alarm active while masked");

    fault_queue_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rstn)
        $rose(flags[`ST_REM_OVER]) && cfg[`CFG_FAULT_QUEUE] |-> cnt_hi == 2'h3)
        else $error("remote over flag before three readings");

    lsb_zero_a: assert property (@(posedge i_core_clk)
        disable iff (!i_rstn)
        req_evt && hold.kind == REQ_READ && ptr == `OFS_REMOTE_LSB
        |=> rd_data[4:0] == 5'h00)
        else $error("remote lsb low bits not zero");

    link_busy_a: assert property (@(posedge i_link_clk) disable iff (!i_rstn)
        i_link_req_valid && o_link_req_ready |=> !o_link_req_ready [*2])
        else $error("link accepted a second request too early");

    conv_c: cover property (@(posedge i_core_clk) disable iff (!i_rstn)
        o_conv_start ##[1:50] state == CONV_STORE);
    oneshot_c: cover property (@(posedge i_core_clk) disable iff (!i_rstn)
        one_due && start_now);
    rsp_c: cover property (@(posedge i_link_clk) disable iff (!i_rstn)
        o_link_rsp_valid);
    fq_c: cover property (@(posedge i_core_clk) disable iff (!i_rstn)
        $rose(flags[`ST_REM_OVER]) && cfg[`CFG_FAULT_QUEUE]);

endmodule // thermal_monitor_register_map

// >>> link_host.sv
`timescale 1ns/1ns
module link_host
    import thermal_monitor_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_ready,
    input wire logic i_rsp_valid,
    input wire logic [7:0] i_rsp_data,
    output logic o_valid,
    output link_req_s o_req
);
    int timeouts = 0;
    initial begin
        o_valid = 1'b0;
        o_req = '0;
    end
    // Request held over one take edge, then answer awaited
    task automatic xfer(input req_kind_e k, input logic [7:0] s, d,
        output logic [7:0] q);
        int n;
        @(negedge i_clk);
        o_valid = 1'b1;
        o_req = '{k, s, d};
        do begin
            @(posedge i_clk);
        end while (i_ready !== 1'b1);
        @(negedge i_clk);
        o_valid = 1'b0;
        o_req = ~o_req;
        for (n = 0; n < 60 && i_rsp_valid !== 1'b1; n++) begin
            @(posedge i_clk);
            #1;
        end
        if (i_rsp_valid !== 1'b1)
            timeouts++;
        q = i_rsp_data;
    endtask
endmodule // link_host

// >>> tb_thermal_monitor_register_map.sv
`timescale 1ns/1ns
module tb_thermal_monitor_register_map
    import thermal_monitor_pkg::*;
;
    logic clk = 0, lclk = 0, rstn = 0, done = 0, open = 0;
    logic valid, ready, rv, start, alm, ot;
    link_req_s req;
    logic [7:0] q, rd, rdata, om, ol, lfsr = 8'h23;
    logic [7:0] rs [8] = '{2, 3, 4, 5, 7, 8'h19, 8'h20, 8'h21};
    logic [7:0] ev [8] = '{0, 0, 8, 8'h46, 8'h46, 8'h55, 8'h55, 8'h0A};
    logic [15:0] t;
    logic signed [9:0] lraw = 0;
    logic signed [13:0] rraw = 0;
    int errors = 0, comparisons = 0, starts = 0, i, n0, lv, v, rc = 0, lc = 0;
    initial forever #20 clk = ~clk;
    initial begin
        #7;
        forever #16 lclk = ~lclk;
    end
    thermal_monitor_register_map #(.CONV_BASE_CYCLES(65536))
        thermal_monitor_register_map_inst (.i_core_clk(clk),
        .i_rstn(rstn), .i_link_clk(lclk), .i_link_req_valid(valid),
        .i_link_req(req), .o_link_req_ready(ready),
        .o_link_rsp_valid(rv), .o_link_rsp_data(rdata),
        .o_conv_start(start), .i_conv_done(done), .i_local_raw(lraw),
        .i_remote_raw(rraw), .i_diode_open(open),
        .o_limit_alarm_oe(alm), .o_overtemp_alarm_out_oe(ot));
    link_host link_host_inst (.i_clk(lclk), .i_ready(ready),
        .i_rsp_valid(rv),
        .i_rsp_data(rdata),
        .o_valid(valid), .o_req(req));
    // Converter answers half a cycle after each start
    always @(negedge clk) begin
        done <= start;
        if (start === 1'b1)
            starts <= starts + 1;
    end
    function automatic logic [7:0] next_rand();
        lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        return lfsr;
    endfunction
    task automatic check(string nm, logic [7:0] e, logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(logic [7:0] s, logic [7:0] d);
        link_host_inst.xfer(REQ_WRITE, s, d, q);
    endtask
    task automatic expect_reg(logic [7:0] s, e, m = 8'hFF);
        link_host_inst.xfer(REQ_SET_PTR, s, 8'h00, q);
        link_host_inst.xfer(REQ_READ, 8'h00, 8'h00, rd);
        check($sformatf("reg %h", s), e & m, rd & m);
    endtask
    task automatic shot();
        int k;
        n0 = starts;
        wr(8'h0F, next_rand());
        for (k = 0; k < 40 && starts == n0; k++) @(posedge clk);
        repeat (4) @(posedge clk);
        check("one-shot starts", 8'h01, 8'(starts - n0));
    endtask
    task automatic complete_run();
        errors += link_host_inst.timeouts;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #1_000_000;
        errors++;
        complete_run();
    end
    initial begin
        repeat (5) @(posedge clk);
        @(negedge clk) rstn = 1'b1;
        link_host_inst.xfer(REQ_READ, 8'h00, 8'h00, rd);
        check("pointer", 8'h00, rd);
        for (i = 0; i < 8; i++) expect_reg(rs[i], ev[i]);
        wr(8'h09, 8'hFF);
        expect_reg(8'h03, 8'hD5);
        wr(8'h09, 8'h40);
        n0 = starts;
        shot();
        repeat (600) @(posedge clk);
        check("starts", 8'h01, 8'(starts - n0));
        expect_reg(8'h0F, 8'h00);
        for (i = 0; i < 6; i++) begin
            om = next_rand();
            ol = next_rand() & 8'hE0;
            wr(8'h11, om);
            wr(8'h12, ol);
            t = {next_rand(), next_rand()};
            lraw = t[9:0];
            rraw = t[15:2];
            shot();
            lv = lraw > 127 ? 127 : (lraw < -128 ? -128 : lraw);
            v = rraw + $signed({om, ol[7:5]});
            v = v > 1023 ? 1023 : (v < -1024 ? -1024 : v);
            expect_reg(8'h00, lv[7:0]);
            expect_reg(8'h01, v[10:3]);
            expect_reg(8'h10, {v[2:0], 5'h0});
            rc = ((v >>> 3) > 85) || (rc != 0 && (v >>> 3) > 75);
            lc = (lv > 85) || (lc != 0 && lv > 75);
            expect_reg(8'h02, {1'b0, lv > 70, lv < 0, v > 560, v < 0,
                1'b0, rc[0], lc[0]});
        end
        open = 1'b1;
        shot();
        expect_reg(8'h01, 8'h7F);
        expect_reg(8'h02, 8'h04, 8'h04);
        open = 1'b0;
        wr(8'h11, 8'h00);
        wr(8'h12, 8'h00);
        wr(8'h09, 8'h41);
        lraw = 10'sd0;
        rraw = 14'sd0;
        shot();
        rraw = 14'sd800;
        for (i = 0; i < 3; i++) begin
            shot();
            check("limit alarm", 8'(i == 2), {7'h0, alm});
            check("overtemp", 8'(i == 2), {7'h0, ot});
            expect_reg(8'h02, i == 2 ? 8'h12 : 8'h00, 8'h12);
        end
        wr(8'h09, 8'hD1);
        shot();
        check("limit alarm", 8'h00, {7'h0, alm});
        check("overtemp", 8'h00, {7'h0, ot});
        wr(8'h09, 8'h41);
        check("limit alarm", 8'h01, {7'h0, alm});
        check("overtemp", 8'h01, {7'h0, ot});
        complete_run();
    end
endmodule // tb_thermal_monitor_register_map
